/* File: src/smb_port.sv */
/*
  Slave-only SMBus register port. Bus side runs on LINK_CLK and
  oversamples SCL/SDA; register side runs on CLK. Requests cross by a
  toggle handshake with a stable payload.
  Assumes: LINK_CLK runs free; the register file answers REG_RDATA and
  REG_DEFINED combinationally for REG_ADDR; straps are static.
*/
`timescale 1ns/1ps
`include "smb_port_defines.svh"

module smb_port #(
  parameter int unsigned TIMEOUT_CYCLES = 32'(`TIMEOUT_CYCLES)
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic LINK_CLK,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic ADDR_ENABLE_N,
  input wire logic ADDR_SELECT,
  input wire logic ALERT_PENDING,
  output logic [7:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  output logic REG_WR,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_DEFINED,
  output logic ALERT_GLOBAL_ENABLE_CLR,
  output logic TACH_INPUT_4_EN,
  output logic FAN_DRIVE_3_EN
);

  // Reset into the link domain; first flop feeds only the second
  logic rst_m_q;
  logic rst_l_q;

  always_ff @(posedge LINK_CLK) begin
    rst_m_q <= SRST;
    rst_l_q <= rst_m_q;
  end

  // Pin and cross-domain synchronisers: ack, alert, sel, en_n, sda, scl
  logic [5:0] sync_m_q;
  logic [5:0] sync_s_q;
  logic ack_tgl_q;
  logic scl_s;
  logic sda_s;
  logic en_n_s;
  logic sel_s;
  logic alert_s;
  logic ack_s;

  always_ff @(posedge LINK_CLK) begin
    sync_m_q <= {ack_tgl_q, ALERT_PENDING, ADDR_SELECT, ADDR_ENABLE_N,
                 SDA_I, SCL_I};
    sync_s_q <= sync_m_q;
  end

  assign {ack_s, alert_s, sel_s, en_n_s, sda_s, scl_s} = sync_s_q;

  // Glitch filter: a line changes only after FILTER_LEN equal samples
  logic [`FILTER_LEN-1:0] scl_h_q, scl_h_d, sda_h_q, sda_h_d;
  logic scl_f_q, scl_f_d, sda_f_q, sda_f_d;

  always_comb begin
    scl_h_d = {scl_h_q[`FILTER_LEN-2:0], scl_s};
    sda_h_d = {sda_h_q[`FILTER_LEN-2:0], sda_s};
    scl_f_d = scl_f_q;
    sda_f_d = sda_f_q;
    if (&scl_h_q) scl_f_d = 1'b1;
    if (~|scl_h_q) scl_f_d = 1'b0;
    if (&sda_h_q) sda_f_d = 1'b1;
    if (~|sda_h_q) sda_f_d = 1'b0;
  end

  always_ff @(posedge LINK_CLK) begin
    if (rst_l_q) begin
      scl_h_q <= '1;
      sda_h_q <= '1;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      scl_h_q <= scl_h_d;
      sda_h_q <= sda_h_d;
      scl_f_q <= scl_f_d;
      sda_f_q <= sda_f_d;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_f_d & ~scl_f_q;
  assign scl_fall = ~scl_f_d & scl_f_q;
  assign bus_start = scl_f_q & scl_f_d & sda_f_q & ~sda_f_d;
  assign bus_stop = scl_f_q & scl_f_d & ~sda_f_q & sda_f_d;

  // Link-side protocol engine
  smb_port_pkg::link_state_e state_q, state_d, ack_to_q, ack_to_d;
  smb_port_pkg::req_s req_q, req_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shreg_q, shreg_d, tx_q, tx_d, idx_q, idx_d;
  logic [7:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic sda_oe_q, sda_oe_d, idx_ok_q, idx_ok_d, wr_pend_q, wr_pend_d;
  logic ara_q, ara_d, req_tgl_q, req_tgl_d, ack_prev_q;
  logic sel_q, sel_d, latched_q, latched_d;
  logic strap_mode_q, strap_mode_d, strap_done_q, strap_done_d;
  logic func_en_q, func_en_d;
  logic [23:0] low_cnt_q, low_cnt_d;
  logic [7:0] byte_in;
  logic [6:0] own_addr;
  logic [7:0] rd_word;
  logic timeout;

  assign byte_in = {shreg_q[6:0], sda_f_d};
  assign own_addr = !strap_mode_q ? `ADDR_DEFAULT :
                    {`ADDR_PREFIX, 1'b0, latched_q ? sel_q : sel_s};
  assign timeout = (state_q != smb_port_pkg::S_IDLE) &&
                   (low_cnt_q >= 24'(TIMEOUT_CYCLES));

  always_comb begin
    state_d = state_q;
    ack_to_d = ack_to_q;
    req_d = req_q;
    req_tgl_d = req_tgl_q;
    cnt_d = cnt_q;
    shreg_d = shreg_q;
    tx_d = tx_q;
    idx_d = idx_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    sda_oe_d = sda_oe_q;
    idx_ok_d = idx_ok_q;
    wr_pend_d = wr_pend_q;
    ara_d = ara_q;
    sel_d = sel_q;
    latched_d = latched_q;
    strap_mode_d = strap_mode_q;
    strap_done_d = 1'b1;
    func_en_d = func_en_q;
    low_cnt_d = scl_f_q ? 24'h000000 :
                (&low_cnt_q ? low_cnt_q : low_cnt_q + 24'h000001);
    if (!strap_done_q) begin
      strap_mode_d = ~en_n_s;
      func_en_d = en_n_s;
    end
    if (ack_s ^ ack_prev_q) rdata_d = rd_word;
    if (bus_stop) begin
      // Write lands only at STOP after a fully acked Write Byte
      if (wr_pend_q) begin
        req_d = '{smb_port_pkg::REQ_WRITE, idx_q, wdata_q};
        req_tgl_d = ~req_tgl_q;
      end
      state_d = smb_port_pkg::S_IDLE;
      sda_oe_d = 1'b0;
      idx_ok_d = 1'b0;
      wr_pend_d = 1'b0;
    end else if (bus_start) begin
      state_d = smb_port_pkg::S_ADDR;
      cnt_d = 4'h0;
      sda_oe_d = 1'b0;
      wr_pend_d = 1'b0;
    end else if (timeout) begin
      state_d = smb_port_pkg::S_IDLE;
      sda_oe_d = 1'b0;
      idx_ok_d = 1'b0;
      wr_pend_d = 1'b0;
    end else begin
      unique case (state_q)
        smb_port_pkg::S_IDLE: begin
        end
        smb_port_pkg::S_ADDR, smb_port_pkg::S_INDEX,
        smb_port_pkg::S_WDATA: begin
          if (scl_rise) begin
            shreg_d = byte_in;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              cnt_d = 4'h0;
              state_d = smb_port_pkg::S_ACK;
              if (state_q == smb_port_pkg::S_ADDR) begin
                ara_d = 1'b0;
                if (strap_mode_q && !latched_q &&
                    byte_in[7:3] == `ADDR_PREFIX) begin
                  latched_d = 1'b1;
                  sel_d = sel_s;
                end
                if (byte_in[7:1] == own_addr && !byte_in[0]) begin
                  ack_to_d = smb_port_pkg::S_INDEX;
                  idx_ok_d = 1'b0;
                end else if (byte_in[7:1] == own_addr && idx_ok_q) begin
                  ack_to_d = smb_port_pkg::S_TX;
                  req_d = '{smb_port_pkg::REQ_READ, idx_q, 8'h00};
                  req_tgl_d = ~req_tgl_q;
                end else if (byte_in[7:1] == `ADDR_ARA && byte_in[0] &&
                             alert_s) begin
                  ack_to_d = smb_port_pkg::S_TX;
                  ara_d = 1'b1;
                  req_d = '{smb_port_pkg::REQ_ALERT_CLR, idx_q, 8'h00};
                  req_tgl_d = ~req_tgl_q;
                end else begin
                  // General call and foreign addresses land here
                  state_d = smb_port_pkg::S_IDLE;
                  idx_ok_d = 1'b0;
                end
              end else if (state_q == smb_port_pkg::S_INDEX) begin
                idx_d = byte_in;
                idx_ok_d = 1'b1;
                ack_to_d = smb_port_pkg::S_WDATA;
              end else begin
                wdata_d = byte_in;
                wr_pend_d = 1'b1;
                idx_ok_d = 1'b0;
                ack_to_d = smb_port_pkg::S_WAIT;
              end
            end
          end
        end
        smb_port_pkg::S_ACK: begin
          if (scl_fall) begin
            if (!sda_oe_q) begin
              sda_oe_d = 1'b1;
            end else begin
              sda_oe_d = 1'b0;
              state_d = ack_to_q;
              cnt_d = 4'h0;
              if (ack_to_q == smb_port_pkg::S_TX) begin
                tx_d = ara_q ? {own_addr, 1'b1} : rdata_q;
                sda_oe_d = ara_q ? ~own_addr[6] : ~rdata_q[7];
              end
            end
          end
        end
        smb_port_pkg::S_TX: begin
          if (scl_rise) cnt_d = cnt_q + 4'h1;
          if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              // One byte only; host acknowledge is not acted on
              sda_oe_d = 1'b0;
              state_d = smb_port_pkg::S_WAIT;
            end else begin
              tx_d = {tx_q[6:0], 1'b0};
              sda_oe_d = ~tx_q[6];
            end
          end
        end
        smb_port_pkg::S_WAIT: begin
          // Extra clocked bits void the write; a STOP only rises SCL
          if (scl_fall) wr_pend_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK) begin
    if (rst_l_q) begin
      state_q <= smb_port_pkg::S_IDLE;
      ack_to_q <= smb_port_pkg::S_IDLE;
      req_q <= '{smb_port_pkg::REQ_READ, 8'h00, 8'h00};
      req_tgl_q <= 1'b0;
      ack_prev_q <= 1'b0;
      cnt_q <= 4'h0;
      shreg_q <= 8'h00;
      tx_q <= 8'h00;
      idx_q <= 8'h00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      sda_oe_q <= 1'b0;
      idx_ok_q <= 1'b0;
      wr_pend_q <= 1'b0;
      ara_q <= 1'b0;
      sel_q <= 1'b0;
      latched_q <= 1'b0;
      strap_mode_q <= 1'b0;
      strap_done_q <= 1'b0;
      func_en_q <= 1'b1;
      low_cnt_q <= 24'h000000;
    end else begin
      state_q <= state_d;
      ack_to_q <= ack_to_d;
      req_q <= req_d;
      req_tgl_q <= req_tgl_d;
      ack_prev_q <= ack_s;
      cnt_q <= cnt_d;
      shreg_q <= shreg_d;
      tx_q <= tx_d;
      idx_q <= idx_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      sda_oe_q <= sda_oe_d;
      idx_ok_q <= idx_ok_d;
      wr_pend_q <= wr_pend_d;
      ara_q <= ara_d;
      sel_q <= sel_d;
      latched_q <= latched_d;
      strap_mode_q <= strap_mode_d;
      strap_done_q <= strap_done_d;
      func_en_q <= func_en_d;
      low_cnt_q <= low_cnt_d;
    end
  end

  // Open-drain lines: only the enable moves; SCL is never pulled
  always_ff @(posedge LINK_CLK) begin
    if (rst_l_q) begin
      SDA_O <= 1'b0;
      SCL_O <= 1'b0;
      SCL_OE <= 1'b0;
    end else begin
      SDA_O <= 1'b0;
      SCL_O <= 1'b0;
      SCL_OE <= 1'b0;
    end
  end

  assign SDA_OE = sda_oe_q;
  assign TACH_INPUT_4_EN = func_en_q;
  assign FAN_DRIVE_3_EN = func_en_q;

  // Core side: request toggle sync, one access per toggle
  logic rq_m_q, rq_s_q, rq_prev_q;
  smb_port_pkg::core_state_e cst_q, cst_d;
  smb_port_pkg::req_kind_e kind_q, kind_d;
  logic [7:0] raddr_q, raddr_d, rwd_q, rwd_d, rdw_q, rdw_d;
  logic wr_q, wr_d, aclr_q, aclr_d, ack_tgl_d;

  always_ff @(posedge CLK) begin
    rq_m_q <= req_tgl_q;
    rq_s_q <= rq_m_q;
  end

  always_comb begin
    cst_d = cst_q;
    kind_d = kind_q;
    raddr_d = raddr_q;
    rwd_d = rwd_q;
    rdw_d = rdw_q;
    wr_d = 1'b0;
    aclr_d = 1'b0;
    ack_tgl_d = ack_tgl_q;
    unique case (cst_q)
      smb_port_pkg::C_IDLE: begin
        // Payload changed on the same link edge as the toggle; the two sync flops let it settle
        if (rq_s_q ^ rq_prev_q) begin
          kind_d = req_q.kind;
          raddr_d = req_q.idx;
          rwd_d = req_q.data;
          cst_d = smb_port_pkg::C_ACC;
        end
      end
      smb_port_pkg::C_ACC: begin
        wr_d = (kind_q == smb_port_pkg::REQ_WRITE) && REG_DEFINED;
        aclr_d = kind_q == smb_port_pkg::REQ_ALERT_CLR;
        rdw_d = REG_DEFINED ? REG_RDATA : `UNDEF_READ;
        ack_tgl_d = ~ack_tgl_q;
        cst_d = smb_port_pkg::C_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rq_prev_q <= 1'b0;
      cst_q <= smb_port_pkg::C_IDLE;
      kind_q <= smb_port_pkg::REQ_READ;
      raddr_q <= 8'h00;
      rwd_q <= 8'h00;
      rdw_q <= 8'h00;
      wr_q <= 1'b0;
      aclr_q <= 1'b0;
      ack_tgl_q <= 1'b0;
    end else begin
      rq_prev_q <= rq_s_q;
      cst_q <= cst_d;
      kind_q <= kind_d;
      raddr_q <= raddr_d;
      rwd_q <= rwd_d;
      rdw_q <= rdw_d;
      wr_q <= wr_d;
      aclr_q <= aclr_d;
      ack_tgl_q <= ack_tgl_d;
    end
  end

  assign rd_word = rdw_q;
  assign REG_ADDR = raddr_q;
  assign REG_WDATA = rwd_q;
  assign REG_WR = wr_q;
  assign ALERT_GLOBAL_ENABLE_CLR = aclr_q;

endmodule : smb_port

/* File: src/smb_port_defines.svh */
/*
  Constants of the SMBus slave register port: bus addresses, strap
  prefix, undefined-read value, filter length and timeout counts.
  Assumes inclusion by bare name from the design file only.
*/
`ifndef SMB_PORT_DEFINES_SVH
`define SMB_PORT_DEFINES_SVH

`define ADDR_DEFAULT 7'h2E
`define ADDR_PREFIX 5'h0B
`define ADDR_ARA 7'h0C
`define UNDEF_READ 8'h00
`define FILTER_LEN 3
`define TIMEOUT_MS 25
`define READY_MS 35
`define LINK_PERIOD_PS 125000
`define TIMEOUT_CYCLES ((`TIMEOUT_MS * 64'd1000000000) / `LINK_PERIOD_PS)

`endif

/* File: src/smb_port_pkg.sv */
/*
  Types of the SMBus slave register port: state enums and the request
  word carried from the bus clock domain to the core domain.
  Assumes nothing of its surroundings.
*/
package smb_port_pkg;

  typedef enum logic [1:0] {
    REQ_READ,
    REQ_WRITE,
    REQ_ALERT_CLR
  } req_kind_e;

  typedef struct packed {
    req_kind_e kind;
    logic [7:0] idx;
    logic [7:0] data;
  } req_s;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_INDEX,
    S_WDATA,
    S_ACK,
    S_TX,
    S_WAIT
  } link_state_e;

  typedef enum logic {
    C_IDLE,
    C_ACC
  } core_state_e;

endpackage : smb_port_pkg

/* File: verif/smb_port_assertions.sv */
/*
  Checker for the SMBus slave register port, bound to smb_port.
  Assumes the bench holds ALERT_PENDING through a whole alert reply.
*/
`timescale 1ns/1ps

module smb_port_assertions #(
  parameter int unsigned TIMEOUT_CYCLES = 200
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic LINK_CLK,
  input wire logic SCL_I,
  input wire logic SCL_OE,
  input wire logic SDA_O,
  input wire logic SDA_OE,
  input wire logic ADDR_ENABLE_N,
  input wire logic ALERT_PENDING,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_DEFINED,
  input wire logic ALERT_GLOBAL_ENABLE_CLR,
  input wire logic TACH_INPUT_4_EN,
  input wire logic FAN_DRIVE_3_EN
);
  logic [3:0] rel_q;
  logic [3:0] rel_d;
  logic [31:0] low_q;
  logic [31:0] low_d;

  // Link cycles since reset release, and SCL low time
  always_comb begin
    rel_d = SRST ? 4'h0 : ((rel_q == 4'hF) ? rel_q : rel_q + 4'h1);
    low_d = SCL_I ? 32'h0 : low_q + 32'h1;
  end

  always_ff @(posedge LINK_CLK) begin
    rel_q <= rel_d;
    low_q <= low_d;
  end

  AST_SCL_NEVER_DRIVEN: assert property (@(posedge LINK_CLK)
    disable iff (SRST) !SCL_OE) else $error("SCL driven");
  AST_SDA_ONLY_LOW: assert property (@(posedge LINK_CLK)
    disable iff (SRST) SDA_OE |-> !SDA_O) else $error("SDA driven high");
  AST_SDA_STILL_SCL_HIGH: assert property (@(posedge LINK_CLK)
    disable iff (SRST) SCL_I [*4] |-> $stable(SDA_OE))
    else $error("SDA moved while SCL high");
  AST_TIMEOUT_RELEASE: assert property (@(posedge LINK_CLK)
    disable iff (SRST) (low_q > TIMEOUT_CYCLES + 10) |-> !SDA_OE)
    else $error("SDA held past timeout");
  AST_STRAP_PINS: assert property (@(posedge LINK_CLK)
    disable iff (SRST) (rel_q == 4'hF) |->
    (TACH_INPUT_4_EN == ADDR_ENABLE_N) && (FAN_DRIVE_3_EN == ADDR_ENABLE_N))
    else $error("pin enables wrong for strap mode");
  AST_WR_ONE_CYCLE: assert property (@(posedge CLK)
    disable iff (SRST) REG_WR |=> !REG_WR) else $error("write pulse long");
  AST_WR_DEFINED_ONLY: assert property (@(posedge CLK)
    disable iff (SRST) REG_WR |-> REG_DEFINED)
    else $error("write to undefined index");
  AST_WR_PAYLOAD_SET: assert property (@(posedge CLK)
    disable iff (SRST) REG_WR |-> $stable(REG_ADDR) && $stable(REG_WDATA))
    else $error("write payload not settled");
  AST_CLR_ONE_CYCLE: assert property (@(posedge CLK)
    disable iff (SRST) ALERT_GLOBAL_ENABLE_CLR |=> !ALERT_GLOBAL_ENABLE_CLR)
    else $error("clear pulse long");
  AST_CLR_WITH_ALERT: assert property (@(posedge CLK)
    disable iff (SRST) ALERT_GLOBAL_ENABLE_CLR |-> ALERT_PENDING)
    else $error("clear without alert");
endmodule : smb_port_assertions

bind smb_port smb_port_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_u (
  .CLK(CLK), .SRST(SRST), .LINK_CLK(LINK_CLK), .SCL_I(SCL_I),
  .SCL_OE(SCL_OE), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
  .ADDR_ENABLE_N(ADDR_ENABLE_N), .ALERT_PENDING(ALERT_PENDING),
  .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_DEFINED(REG_DEFINED),
  .ALERT_GLOBAL_ENABLE_CLR(ALERT_GLOBAL_ENABLE_CLR),
  .TACH_INPUT_4_EN(TACH_INPUT_4_EN), .FAN_DRIVE_3_EN(FAN_DRIVE_3_EN)
);

/* File: verif/smb_host.sv */
/*
  Behavioural SMBus host: START, STOP, byte send and receive.
  Assumes the bench wires SCL and SDA as pulled-up open-drain lines.
*/
`timescale 1ns/1ps

module smb_host #(
  parameter int HALF = 80
) (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hp();
    repeat (HALF) @(negedge clk);
  endtask : hp

  // Also a repeated START when entered with SCL low
  task automatic start();
    sda_low = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b1;
    hp();
    scl = 1'b0;
    hp();
  endtask : start

  task automatic stop();
    sda_low = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b0;
    hp();
  endtask : stop

  // Late sample: the slave answers several link cycles after SCL falls
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    hp();
    scl = 1'b1;
    hp();
    r = sda;
    scl = 1'b0;
  endtask : bit_io

  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask : send

  task automatic recv(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
  endtask : recv

  task automatic hold(input int n);
    scl = 1'b0;
    repeat (n) @(negedge clk);
  endtask : hold
endmodule : smb_host

/* File: verif/test_smbus_slave_register_port.sv */
/*
  Testbench of the SMBus slave register port with a host model and a
  register file model. Assumes the checker is bound to smb_port.
*/
`timescale 1ns/1ps

module test_smbus_slave_register_port;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic srst = 1'b1;
  logic adr_en_n = 1'b1;
  logic adr_sel = 1'b0;
  logic alert = 1'b0;
  logic scl_h, sda_low, scl_o, scl_oe, sda_o, sda_oe;
  logic reg_wr, clr, tach, fan;
  logic [7:0] reg_addr, reg_wdata;
  logic [7:0] regs [256];
  int mismatches = 0;
  int n_checks = 0;
  int wr_n = 0;
  int clr_n = 0;
  int cyc = 0;
  wire logic scl_w = scl_h & !(scl_oe & !scl_o);
  wire logic sda_w = !sda_low & !(sda_oe & !sda_o);
  wire logic [7:0] reg_rdata = regs[reg_addr];
  wire logic reg_defined = (reg_addr < 8'h80);

  always #5 clk = ~clk;
  initial begin
    #3.3;
    forever #62.5 link_clk = ~link_clk;
  end

  smb_port #(.TIMEOUT_CYCLES(200)) dut_u (
    .CLK(clk), .SRST(srst), .LINK_CLK(link_clk), .SCL_I(scl_w),
    .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda_w), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .ADDR_ENABLE_N(adr_en_n), .ADDR_SELECT(adr_sel),
    .ALERT_PENDING(alert), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RDATA(reg_rdata), .REG_DEFINED(reg_defined),
    .ALERT_GLOBAL_ENABLE_CLR(clr), .TACH_INPUT_4_EN(tach),
    .FAN_DRIVE_3_EN(fan)
  );

  smb_host #(.HALF(80)) host_u (
    .clk(clk), .sda(sda_w), .scl(scl_h), .sda_low(sda_low)
  );

  // Non-zero fill exposes a read that ignores the defined flag
  initial begin
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'hC3;
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (reg_wr) begin
      regs[reg_addr] <= reg_wdata;
      wr_n <= wr_n + 1;
    end
    if (clr) begin
      clr_n <= clr_n + 1;
    end
    if (cyc == 100000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got 0x%0h expected 0x%0h", $time, got, exp);
    end
  endtask : chk

  // Reset long enough for the link side to see it
  task automatic do_reset();
    srst = 1'b1;
    repeat (50) @(negedge clk);
    srst = 1'b0;
    repeat (200) @(negedge clk);
  endtask : do_reset

  task automatic wr_txn(input logic [6:0] a, input logic [7:0] i,
                        input logic [7:0] d, output logic [2:0] k);
    host_u.start();
    host_u.send({a, 1'b0}, k[2]);
    host_u.send(i, k[1]);
    host_u.send(d, k[0]);
    host_u.stop();
    repeat (40) @(negedge clk);
  endtask : wr_txn

  task automatic rd_txn(input logic [6:0] a, input logic [7:0] i,
                        output logic [7:0] d, output logic [2:0] k);
    host_u.start();
    host_u.send({a, 1'b0}, k[2]);
    host_u.send(i, k[1]);
    host_u.start();
    host_u.send({a, 1'b1}, k[0]);
    host_u.recv(d);
    host_u.stop();
  endtask : rd_txn

  task automatic t_write_read();
    logic [2:0] k;
    logic [7:0] d;
    int w0;
    w0 = wr_n;
    chk({6'h0, tach, fan}, 8'h03);
    wr_txn(7'h2E, 8'h10, 8'hA5, k);
    chk({5'h0, k}, 8'h07);
    chk(8'(wr_n - w0), 8'h01);
    chk(regs[8'h10], 8'hA5);
    rd_txn(7'h2E, 8'h10, d, k);
    chk({5'h0, k}, 8'h07);
    chk(d, 8'hA5);
    $display("t_write_read done");
  endtask : t_write_read

  task automatic t_undefined();
    logic [2:0] k;
    logic [7:0] d;
    int w0;
    rd_txn(7'h2E, 8'hF0, d, k);
    chk(d, 8'h00);
    w0 = wr_n;
    wr_txn(7'h2E, 8'hF0, 8'h5A, k);
    chk({5'h0, k}, 8'h07);
    chk(8'(wr_n - w0), 8'h00);
    $display("t_undefined done");
  endtask : t_undefined

  task automatic t_refuse();
    logic [7:0] bad [3] = '{8'h00, 8'h5E, 8'h19};
    logic k;
    int w0;
    foreach (bad[i]) begin
      host_u.start();
      host_u.send(bad[i], k);
      chk({7'h0, k}, 8'h00);
      host_u.stop();
    end
    w0 = wr_n;
    host_u.start();
    host_u.send(8'h5C, k);
    host_u.send(8'h11, k);
    host_u.send(8'h77, k);
    host_u.send(8'h88, k);
    chk({7'h0, k}, 8'h00);
    host_u.stop();
    repeat (40) @(negedge clk);
    chk(8'(wr_n - w0), 8'h00);
    $display("t_refuse done");
  endtask : t_refuse

  task automatic t_alert();
    logic k;
    logic [7:0] d;
    int c0;
    c0 = clr_n;
    alert = 1'b1;
    host_u.start();
    host_u.send(8'h19, k);
    chk({7'h0, k}, 8'h01);
    host_u.recv(d);
    host_u.stop();
    repeat (40) @(negedge clk);
    alert = 1'b0;
    chk({1'b0, d[7:1]}, 8'h2E);
    chk(8'(clr_n - c0), 8'h01);
    $display("t_alert done");
  endtask : t_alert

  task automatic t_timeout();
    logic k;
    int w0;
    w0 = wr_n;
    host_u.start();
    host_u.send(8'h5C, k);
    host_u.send(8'h12, k);
    host_u.hold(3500);
    host_u.send(8'h66, k);
    chk({7'h0, k}, 8'h00);
    host_u.stop();
    repeat (40) @(negedge clk);
    chk(8'(wr_n - w0), 8'h00);
    $display("t_timeout done");
  endtask : t_timeout

  task automatic t_bus_reset();
    logic k;
    host_u.start();
    host_u.send(8'h5C, k);
    host_u.send(8'h13, k);
    host_u.start();
    host_u.stop();
    host_u.send(8'hD5, k);
    chk({7'h0, k}, 8'h00);
    host_u.stop();
    $display("t_bus_reset done");
  endtask : t_bus_reset

  task automatic t_strap();
    logic [2:0] k;
    logic a;
    adr_en_n = 1'b0;
    adr_sel = 1'b0;
    do_reset();
    chk({6'h0, tach, fan}, 8'h00);
    host_u.start();
    host_u.send(8'h5C, a);
    chk({7'h0, a}, 8'h00);
    host_u.stop();
    wr_txn(7'h2C, 8'h14, 8'h3C, k);
    chk({5'h0, k}, 8'h07);
    adr_sel = 1'b1;
    host_u.start();
    host_u.send(8'h58, a);
    chk({7'h0, a}, 8'h01);
    host_u.stop();
    chk(regs[8'h14], 8'h3C);
    // Select high at power up gives the other strap address
    do_reset();
    wr_txn(7'h2D, 8'h15, 8'h4B, k);
    chk({5'h0, k}, 8'h07);
    chk(regs[8'h15], 8'h4B);
    $display("t_strap done");
  endtask : t_strap

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    do_reset();
    t_write_read();
    t_undefined();
    t_refuse();
    t_alert();
    t_timeout();
    t_bus_reset();
    t_strap();
    tally_and_finish();
  end
endmodule : test_smbus_slave_register_port
